// [logic/cross_arm_trigger_sequencer.sv]
`default_nettype none

module cross_arm_trigger_sequencer import xarm_pkg::*; #(
  parameter int MEM_AW = 10
) (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic                   run_start,
  input  wire logic                   run_end,
  input  wire logic                   count_time,
  input  wire logic                   b_timing,
  input  wire level_cfg_t [LVL_N-1:0] cfg_a,
  input  wire level_cfg_t [LVL_N-1:0] cfg_b,
  input  wire arm_src_t               arm_src_a,
  input  wire arm_src_t               arm_src_b,
  input  wire logic                   manual_a,
  input  wire logic                   manual_b,
  input  wire logic [MEM_AW-1:0]      trig_pos_a,
  input  wire logic [MEM_AW-1:0]      trig_pos_b,
  input  wire logic [CH_W-1:0]        a_data,
  input  wire logic                   a_valid,
  input  wire logic [CH_W-1:0]        b_data,
  input  wire logic                   b_valid,
  input  wire logic [CH_W-1:0]        b_xing,
  input  wire logic                   glitch_mode,
  input  wire logic                   pod_toggle,
  input  wire logic [CH_W-1:0]        edge_rise_mask,
  input  wire logic [CH_W-1:0]        edge_fall_mask,
  input  wire logic [CH_W-1:0]        edge_glitch_mask,
  input  wire logic                   scope_input_one,
  input  wire logic                   scope_edge_rise,
  input  wire logic                   scope_arm_sel,
  input  wire logic                   scope_immediate,
  input  wire logic [`SKEW_W-1:0]     skew,
  output logic                        a_arm,
  output logic                        a_store,
  output logic [MEM_AW-1:0]           a_addr,
  output logic [TAG_W-1:0]            a_tag,
  output logic                        a_done,
  output logic                        b_arm,
  output logic                        b_store,
  output logic [MEM_AW-1:0]           b_addr,
  output logic [TAG_W-1:0]            b_tag,
  output logic                        b_done,
  output logic [CH_W-1:0]             glitch_flags,
  output logic                        pod_sel,
  output logic [`RATE_W-1:0]          rate_mhz,
  output logic                        scope_trig,
  output logic                        scope_arm_out
);

  localparam int POD_W = `POD_W;
  localparam int SKEW_MAX = `SKEW_MAX;

  // ****************************************************************
  // Helpers.
  // ****************************************************************

  // Pattern term: masked channels must equal the value; mask 0 is any.
  function automatic logic pat_match(input logic [CH_W-1:0] data,
                                     input logic [CH_W-1:0] mask,
                                     input logic [CH_W-1:0] val);
    pat_match = ((data ^ val) & mask) == '0;
  endfunction

  // Arm level seen by a unit; a unit run by nobody is always enabled.
  function automatic logic arm_level(input arm_src_t src,
                                     input logic peer,
                                     input logic scope);
    unique case (src)
      ARM_PEER:  arm_level = peer;
      ARM_SCOPE: arm_level = scope;
      default:   arm_level = 1'b1;
    endcase
  endfunction

  unit_if #(.MEM_AW(MEM_AW)) ua ();
  unit_if #(.MEM_AW(MEM_AW)) ub ();

  // ****************************************************************
  // Timing front end: pods, glitch capture, edge term.
  // ****************************************************************
  logic [1:0]        xcnt_q [CH_W];
  logic [1:0]        xcnt_d [CH_W];
  logic [CH_W-1:0]   prev_q, prev_d;
  logic [CH_W-1:0]   glitch_q, glitch_d;
  logic              pod_q, pod_d;
  logic [`RATE_W-1:0] rate_q, rate_d;
  logic [CH_W-1:0]   chan_mask;
  logic [CH_W-1:0]   gl_now;
  logic [CH_W-1:0]   b_live;
  logic              edge_hit;

  // Crossing counts per channel and the edge term of the timing unit.
  always_comb begin
    // Half-channel glitch mode keeps only the selected pod.
    chan_mask = '1;
    if (glitch_mode) begin
      chan_mask = pod_q ? {{POD_W{1'b1}}, {POD_W{1'b0}}}
                        : {{POD_W{1'b0}}, {POD_W{1'b1}}};
    end
    b_live = b_data & chan_mask;
    for (int ch = 0; ch < CH_W; ch++) begin
      // Two or more crossings since the last sample make a glitch.
      gl_now[ch] = xcnt_q[ch][1] | (xcnt_q[ch][0] & b_xing[ch]);
      if (b_valid) begin
        xcnt_d[ch] = 2'h0;
      end else if (b_xing[ch] && !xcnt_q[ch][1]) begin
        xcnt_d[ch] = xcnt_q[ch] + 2'h1;
      end else begin
        xcnt_d[ch] = xcnt_q[ch];
      end
    end
    gl_now   = gl_now & chan_mask & {CH_W{glitch_mode & b_timing}};
    glitch_d = b_valid ? gl_now : glitch_q;
    prev_d   = b_valid ? b_live : prev_q;
    pod_d    = pod_toggle ? ~pod_q : pod_q;
    rate_d   = glitch_mode ? `GLITCH_RATE_MHZ : `FULL_RATE_MHZ;
    edge_hit = |(( b_live & ~prev_q & edge_rise_mask)
               | (~b_live &  prev_q & edge_fall_mask)
               | (gl_now & edge_glitch_mask));
  end

  // Registers of the timing front end.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      for (int ch = 0; ch < CH_W; ch++) begin
        xcnt_q[ch] <= 2'h0;
      end
      prev_q   <= '0;
      glitch_q <= '0;
      pod_q    <= 1'b0;
      rate_q   <= `FULL_RATE_MHZ;
    end else begin
      for (int ch = 0; ch < CH_W; ch++) begin
        xcnt_q[ch] <= xcnt_d[ch];
      end
      prev_q   <= prev_d;
      glitch_q <= glitch_d;
      pod_q    <= pod_d;
      rate_q   <= rate_d;
    end
  end

  // ****************************************************************
  // Oscilloscope trigger and arm path.
  // ****************************************************************
  logic                run_q, run_d;
  logic                sprev_q, sprev_d;
  logic                strig_q, strig_d;
  logic [SKEW_MAX:0]   dly_q, dly_d;
  logic                sarm_q, sarm_d;
  logic                scope_edge;
  logic [`SKEW_W-1:0]  tap;

  // Scope edge trigger on its first input, and the skewed arm delay.
  always_comb begin
    run_d      = run_start | (run_q & ~run_end);
    sprev_d    = scope_input_one;
    scope_edge = scope_edge_rise ? (scope_input_one & ~sprev_q)
                                 : (~scope_input_one & sprev_q);
    // A new edge wins over the clear of a new run.
    strig_d    = (scope_edge & run_q) | (strig_q & ~run_start);
    dly_d      = {dly_q[SKEW_MAX-1:0],
                  scope_arm_sel ? ub.arm : ua.arm};
    // Larger skew taps earlier, so the scope fires sooner.
    tap        = `SKEW_W'(SKEW_MAX) - skew;
    sarm_d     = scope_immediate & dly_q[tap];
  end

  // Registers of the oscilloscope path.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      run_q   <= 1'b0;
      sprev_q <= 1'b0;
      strig_q <= 1'b0;
      dly_q   <= '0;
      sarm_q  <= 1'b0;
    end else begin
      run_q   <= run_d;
      sprev_q <= sprev_d;
      strig_q <= strig_d;
      dly_q   <= dly_d;
      sarm_q  <= sarm_d;
    end
  end

  // ****************************************************************
  // Level terms of both units.
  // ****************************************************************
  logic arm_in_a;
  logic arm_in_b;

  // Unit A is always a state unit, so two timing units never occur.
  always_comb begin
    arm_in_a        = arm_level(arm_src_a, ub.arm, strig_q);
    arm_in_b        = arm_level(arm_src_b, ua.arm, strig_q);
    ua.sample_valid = a_valid;
    ub.sample_valid = b_valid;
    for (int l = 0; l < LVL_N; l++) begin
      // The arm level gates the level's own term directly.
      ua.trig_hit[l]  = arm_in_a
                      & pat_match(a_data, cfg_a[l].trig_mask,
                                  cfg_a[l].trig_val);
      ua.else_hit[l]  = pat_match(a_data, cfg_a[l].else_mask,
                                  cfg_a[l].else_val);
      ua.store_hit[l] = pat_match(a_data, cfg_a[l].store_mask,
                                  cfg_a[l].store_val);
      ub.trig_hit[l]  = arm_in_b
                      & pat_match(b_live, cfg_b[l].trig_mask,
                                  cfg_b[l].trig_val)
                      & (~(b_timing & cfg_b[l].use_edge) | edge_hit);
      ub.else_hit[l]  = pat_match(b_live, cfg_b[l].else_mask,
                                  cfg_b[l].else_val);
      ub.store_hit[l] = pat_match(b_live, cfg_b[l].store_mask,
                                  cfg_b[l].store_val);
    end
  end

  // ****************************************************************
  // Sequencers.
  // ****************************************************************
  seq_unit #(.MEM_AW(MEM_AW)) u_seq_a (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .run_start  (run_start),
    .run_end    (run_end),
    .cfg        (cfg_a),
    .manual     (manual_a),
    .trig_pos   (trig_pos_a),
    .count_time (count_time),
    .u          (ua.unit)
  );

  seq_unit #(.MEM_AW(MEM_AW)) u_seq_b (
    .clk_sys    (clk_sys),
    .rst        (rst),
    .run_start  (run_start),
    .run_end    (run_end),
    .cfg        (cfg_b),
    .manual     (manual_b),
    .trig_pos   (trig_pos_b),
    .count_time (count_time),
    .u          (ub.unit)
  );

  // Outputs, each from a flip-flop here or in a sequencer.
  assign a_arm         = ua.arm;
  assign a_store       = ua.store;
  assign a_addr        = ua.addr;
  assign a_tag         = ua.tag;
  assign a_done        = ua.done;
  assign b_arm         = ub.arm;
  assign b_store       = ub.store;
  assign b_addr        = ub.addr;
  assign b_tag         = ub.tag;
  assign b_done        = ub.done;
  assign glitch_flags  = glitch_q;
  assign pod_sel       = pod_q;
  assign rate_mhz      = rate_q;
  assign scope_trig    = strig_q;
  assign scope_arm_out = sarm_q;

endmodule

`default_nettype wire

// [logic/xarm_defs.svh]
// Overview of operation
// - Timing unit trigger drives outgoing arm true.
// - Armed state unit, don't-care term, triggers immediately.
// - Incoming arm ANDed with current level term.
// - State unit match emits arm to partner.
// - Armed timing unit needs arm and edge.
// - Level fires after count; else branches.
// - Storage qualifier per level; any-state stores all.
// - Two threshold crossings between samples flag glitch.
// - Glitch mode is half-channel at 125 MHz.
// - Glitch mode uses one pod; pod toggles.
// - Manual mode places trigger anywhere in memory.
// - Scope edge trigger arms the responding unit.
// - Scope arm path skew lets scope trigger earlier.
// - One state plus timing, or two state units.
// - Time tag stored with samples when enabled.
`ifndef XARM_DEFS_SVH
`define XARM_DEFS_SVH

// ****************************************************************
// Widths, counts and rates.
// ****************************************************************
`define CH_W            16
`define POD_W           8
`define LVL_N           4
`define OCC_W           8
`define TAG_W           24
`define RATE_W          10
`define GLITCH_RATE_MHZ 10'd125
`define FULL_RATE_MHZ   10'd250
`define SKEW_MAX        7
`define SKEW_W          3

`endif

// [logic/xarm_pkg.sv]
`default_nettype none
`include "xarm_defs.svh"

package xarm_pkg;

  // ****************************************************************
  // Sizes shared by all files.
  // ****************************************************************
  localparam int CH_W  = `CH_W;
  localparam int LVL_N = `LVL_N;
  localparam int LVL_W = $clog2(`LVL_N);
  localparam int OCC_W = `OCC_W;
  localparam int TAG_W = `TAG_W;

  // Source of the arm level that a unit waits for.
  typedef enum logic [1:0] {
    ARM_NONE  = 2'b00,
    ARM_PEER  = 2'b01,
    ARM_SCOPE = 2'b10
  } arm_src_t;

  // Run state of one acquisition unit.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SEEK = 2'b01,
    ST_POST = 2'b10,
    ST_DONE = 2'b11
  } unit_state_t;

  // Setup of one trigger sequence level.
  typedef struct packed {
    logic [CH_W-1:0]  trig_mask;
    logic [CH_W-1:0]  trig_val;
    logic             use_edge;
    logic [OCC_W-1:0] occur;
    logic             is_trig;
    logic             else_en;
    logic [CH_W-1:0]  else_mask;
    logic [CH_W-1:0]  else_val;
    logic [LVL_W-1:0] else_lvl;
    logic             store_any;
    logic [CH_W-1:0]  store_mask;
    logic [CH_W-1:0]  store_val;
  } level_cfg_t;

endpackage

`default_nettype wire

// [logic/unit_if.sv]
`default_nettype none

// Term results in, sequencer results out, for one acquisition unit.
interface unit_if import xarm_pkg::*; #(
  parameter int MEM_AW = 10
) ();
  logic [LVL_N-1:0]  trig_hit;
  logic [LVL_N-1:0]  else_hit;
  logic [LVL_N-1:0]  store_hit;
  logic              sample_valid;
  logic              arm;
  logic              store;
  logic [MEM_AW-1:0] addr;
  logic [TAG_W-1:0]  tag;
  logic              done;

  modport ctl (
    output trig_hit,
    output else_hit,
    output store_hit,
    output sample_valid,
    input  arm,
    input  store,
    input  addr,
    input  tag,
    input  done
  );

  modport unit (
    input  trig_hit,
    input  else_hit,
    input  store_hit,
    input  sample_valid,
    output arm,
    output store,
    output addr,
    output tag,
    output done
  );
endinterface

`default_nettype wire

// [logic/seq_unit.sv]
`default_nettype none

module seq_unit import xarm_pkg::*; #(
  parameter int MEM_AW = 10
) (
  input  wire logic                    clk_sys,
  input  wire logic                    rst,
  input  wire logic                    run_start,
  input  wire logic                    run_end,
  input  wire level_cfg_t [LVL_N-1:0]  cfg,
  input  wire logic                    manual,
  input  wire logic [MEM_AW-1:0]       trig_pos,
  input  wire logic                    count_time,
  unit_if.unit                         u
);

  // ****************************************************************
  // Sequencer state.
  // ****************************************************************
  unit_state_t       st_q, st_d;
  logic [LVL_W-1:0]  lvl_q, lvl_d;
  logic [OCC_W-1:0]  occ_q, occ_d;
  logic [MEM_AW-1:0] addr_q, addr_d;
  logic [MEM_AW-1:0] post_q, post_d;
  logic [TAG_W-1:0]  time_q, time_d;
  logic [TAG_W-1:0]  tag_q, tag_d;
  logic              arm_q, arm_d;
  logic              store_q, store_d;
  logic              done_q, done_d;
  logic              trig_now;

  // True once this hit completes the programmed count; zero counts as one.
  function automatic logic count_reached(input logic [OCC_W-1:0] occ,
                                         input logic [OCC_W-1:0] occur);
    logic [OCC_W:0] seen;
    seen = {1'b0, occ} + {{OCC_W{1'b0}}, 1'b1};
    count_reached = (seen >= {1'b0, occur});
  endfunction

  // Next state of the sequence levels, storage and post-trigger fill.
  always_comb begin
    st_d     = st_q;
    lvl_d    = lvl_q;
    occ_d    = occ_q;
    addr_d   = addr_q;
    post_d   = post_q;
    time_d   = time_q + {{(TAG_W-1){1'b0}}, 1'b1};
    tag_d    = tag_q;
    arm_d    = arm_q;
    store_d  = 1'b0;
    done_d   = done_q;
    trig_now = 1'b0;
    if (run_start) begin
      st_d   = ST_SEEK;
      lvl_d  = '0;
      occ_d  = '0;
      addr_d = '0;
      time_d = '0;
      arm_d  = 1'b0;
      done_d = 1'b0;
    end else begin
      unique case (st_q)
        ST_IDLE, ST_DONE: begin
        end
        ST_SEEK, ST_POST: begin
          if (u.sample_valid) begin
            store_d = cfg[lvl_q].store_any | u.store_hit[lvl_q];
            if (store_d) begin
              addr_d = addr_q + {{(MEM_AW-1){1'b0}}, 1'b1};
              tag_d  = count_time ? time_q : '0;
            end
            if (st_q == ST_SEEK) begin
              if (u.trig_hit[lvl_q]) begin
                if (count_reached(occ_q, cfg[lvl_q].occur)) begin
                  occ_d = '0;
                  if (cfg[lvl_q].is_trig) begin
                    trig_now = 1'b1;
                    arm_d    = 1'b1;
                    st_d     = ST_POST;
                    // One less than the samples left to store after the trigger.
                    post_d   = manual ? ~trig_pos
                                      : {1'b0, {(MEM_AW-1){1'b1}}};
                  end else begin
                    lvl_d = lvl_q + {{(LVL_W-1){1'b0}}, 1'b1};
                  end
                end else begin
                  occ_d = occ_q + {{(OCC_W-1){1'b0}}, 1'b1};
                end
              end else if (cfg[lvl_q].else_en && u.else_hit[lvl_q]) begin
                lvl_d = cfg[lvl_q].else_lvl;
                occ_d = '0;
              end
            end else if (store_d) begin
              if (post_q == '0) begin
                st_d   = ST_DONE;
                done_d = 1'b1;
              end else begin
                post_d = post_q - {{(MEM_AW-1){1'b0}}, 1'b1};
              end
            end
          end
        end
      endcase
      // Run end stops the unit; a trigger in the same cycle still arms.
      if (run_end) begin
        st_d = ST_IDLE;
        if (!trig_now) begin
          arm_d = 1'b0;
        end
      end
    end
  end

  // Registers of the sequencer.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      st_q    <= ST_IDLE;
      lvl_q   <= '0;
      occ_q   <= '0;
      addr_q  <= '0;
      post_q  <= '0;
      time_q  <= '0;
      tag_q   <= '0;
      arm_q   <= 1'b0;
      store_q <= 1'b0;
      done_q  <= 1'b0;
    end else begin
      st_q    <= st_d;
      lvl_q   <= lvl_d;
      occ_q   <= occ_d;
      addr_q  <= addr_d;
      post_q  <= post_d;
      time_q  <= time_d;
      tag_q   <= tag_d;
      arm_q   <= arm_d;
      store_q <= store_d;
      done_q  <= done_d;
    end
  end

  assign u.arm   = arm_q;
  assign u.store = store_q;
  assign u.addr  = addr_q;
  assign u.tag   = tag_q;
  assign u.done  = done_q;

endmodule

`default_nettype wire

// [sim/xarm_checker_sva.sv]
`default_nettype none
`include "xarm_defs.svh"

module xarm_checker import xarm_pkg::*; #(
  parameter int MEM_AW = 10
) (
  input wire logic                clk_sys,
  input wire logic                rst,
  input wire logic                run_start,
  input wire logic                run_end,
  input wire logic                count_time,
  input wire logic                glitch_mode,
  input wire logic                pod_toggle,
  input wire logic                a_valid,
  input wire arm_src_t            arm_src_b,
  input wire logic                a_arm,
  input wire logic                a_store,
  input wire logic [MEM_AW-1:0]   a_addr,
  input wire logic [TAG_W-1:0]    a_tag,
  input wire logic                a_done,
  input wire logic                b_arm,
  input wire logic                pod_sel,
  input wire logic [`RATE_W-1:0]  rate_mhz
);

  // ****************************************************************
  // Properties on both units and the front end, all in the system clock domain.
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  // A run begins, and unit A raises its arm.
  sequence s_run;
    run_start;
  endsequence

  sequence s_trig_a;
    $rose(a_arm);
  endsequence

  AST_ARM_CLEAR: assert property (
    s_run |=> !a_arm && !b_arm && !a_done)
    else $error("arm not cleared");
  AST_ARM_HOLD: assert property (
    a_arm && !run_start && !run_end |=> a_arm)
    else $error("arm dropped");
  AST_ARM_CAUSE: assert property (s_trig_a |-> $past(a_valid))
    else $error("arm without sample");
  AST_PEER_GATE: assert property (
    $rose(b_arm) && arm_src_b == ARM_PEER |-> $past(a_arm))
    else $error("peer arm missing");
  AST_STORE_ADDR: assert property (
    a_store |-> a_addr == MEM_AW'($past(a_addr) + 1'b1))
    else $error("bad write pointer");
  AST_STORE_CAUSE: assert property (a_store |-> $past(a_valid))
    else $error("store without sample");
  AST_DONE_HOLD: assert property (
    a_done && !run_start |=> a_done && !a_store)
    else $error("done not held");
  AST_RATE: assert property (
    rate_mhz == ($past(glitch_mode) ? 10'h07D : 10'h0FA))
    else $error("bad sample rate");
  AST_POD_FLIP: assert property (
    pod_toggle |=> pod_sel != $past(pod_sel))
    else $error("pod did not flip");
  AST_TAG_OFF: assert property (
    a_store && !$past(count_time) |-> a_tag == '0)
    else $error("tag not zero");

endmodule

bind cross_arm_trigger_sequencer xarm_checker #(.MEM_AW(MEM_AW))
  i_xarm_checker (.*);

`default_nettype wire

// [sim/target_model.sv]
`default_nettype none

module target_model import xarm_pkg::*; (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             go,
  input  wire logic             slow,
  output logic                  a_valid,
  output logic [CH_W-1:0]       a_data
);
  timeunit 1ns;
  timeprecision 100ps;

  logic [CH_W-1:0] idx_q;
  logic [1:0]      gap_q;

  // Counting state stream; slow mode gives one sample every third cycle.
  // Between samples the data lines toggle instead of holding.
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      idx_q   <= '0;
      gap_q   <= '0;
      a_valid <= 1'h0;
      a_data  <= '0;
    end else if (!go || (slow && gap_q != 2'h2)) begin
      gap_q   <= go ? gap_q + 2'h1 : 2'h0;
      idx_q   <= go ? idx_q : '0;
      a_valid <= #1 1'h0;
      a_data  <= #1 ~a_data;
    end else begin
      gap_q   <= '0;
      idx_q   <= idx_q + 1'b1;
      a_valid <= #1 1'h1;
      a_data  <= #1 idx_q;
    end
  end
endmodule

`default_nettype wire

// [sim/testbench.sv]
`default_nettype none
`include "xarm_defs.svh"

module testbench import xarm_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int AW = 4;

  typedef struct packed {
    logic [15:0] mask;
    logic [15:0] val;
    logic [7:0]  occ;
    logic [15:0] emask;
    logic        man;
    logic        slow;
    logic [2:0]  skew;
    logic [3:0]  exp_addr;
    logic [7:0]  exp_cnt;
  } row_t;

  logic                   clk_sys, rst, run_start, run_end, count_time;
  logic                   b_timing, manual_a, manual_b, a_valid, b_valid;
  logic                   glitch_mode, pod_toggle, scope_input_one;
  logic                   scope_edge_rise, scope_arm_sel, scope_immediate;
  logic                   a_arm, a_store, a_done, b_arm, b_store, b_done;
  logic                   pod_sel, scope_trig, scope_arm_out, go, slow, b_run;
  level_cfg_t [LVL_N-1:0] cfg_a, cfg_b;
  arm_src_t               arm_src_a, arm_src_b;
  logic [AW-1:0]          trig_pos_a, trig_pos_b, a_addr, b_addr;
  logic [CH_W-1:0]        a_data, b_data, b_xing, glitch_flags;
  logic [CH_W-1:0]        edge_rise_mask, edge_fall_mask, edge_glitch_mask;
  logic [`SKEW_W-1:0]     skew;
  logic [TAG_W-1:0]       a_tag, b_tag;
  logic [`RATE_W-1:0]     rate_mhz;
  int                     mismatches, cmp_count;

  // Trigger value, occurrence, else term, memory mode, pace, skew, results.
  row_t rows [0:4] = '{
    '{16'hFFFF, 16'h0003, 8'h01, 16'h0000, 1'h0, 1'h0, 3'h0, 4'h4, 8'h08},
    '{16'h0000, 16'h0000, 8'h01, 16'h0000, 1'h0, 1'h1, 3'h7, 4'h1, 8'h08},
    '{16'h0001, 16'h0001, 8'h03, 16'h0000, 1'h1, 1'h0, 3'h3, 4'h6, 8'h04},
    '{16'h0001, 16'h0001, 8'h00, 16'h0000, 1'h0, 1'h0, 3'h0, 4'h2, 8'h08},
    '{16'h0001, 16'h0001, 8'h02, 16'h0002, 1'h0, 1'h0, 3'h5, 4'h6, 8'h08}
  };

  cross_arm_trigger_sequencer #(.MEM_AW(AW))
    i_cross_arm_trigger_sequencer (.*);

  target_model i_target_model (
    .clk_sys(clk_sys), .rst(rst), .go(go), .slow(slow),
    .a_valid(a_valid), .a_data(a_data)
  );

  // ****************************************************************
  // Clock, unit B sample stream and helpers.
  // ****************************************************************
  initial clk_sys = 1'h0;
  always #25 clk_sys = ~clk_sys;

  // Unit B sees a sample every cycle with channel 0 toggling.
  always @(posedge clk_sys) begin
    if (b_run) begin
      b_valid <= #1 1'h1;
      b_data  <= #1 b_data ^ 16'h0001;
    end
  end

  task automatic tick;
    @(posedge clk_sys);
    #1;
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_val(16'(got), 16'(exp));
  endtask

  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wait_until(ref logic s, input int lim);
    for (int n = 0; n < lim && s !== 1'h1; n++) tick;
  endtask

  task automatic pulse_start;
    run_start = 1'h1;
    tick;
    run_start = 1'h0;
  endtask

  task automatic pulse_end;
    go = 1'h0;
    run_end = 1'h1;
    tick;
    run_end = 1'h0;
  endtask

  // One run of unit A: trigger point, post fill count and scope arm delay.
  task automatic run_row(input row_t r, input logic exp_b);
    int n;
    int d;
    repeat (12) tick;
    cfg_a = '0;
    cfg_a[0].is_trig = 1'h1;
    cfg_a[0].store_any = 1'h1;
    cfg_a[0].trig_mask = r.mask;
    cfg_a[0].trig_val = r.val;
    cfg_a[0].occur = r.occ;
    cfg_a[0].else_en = |r.emask;
    cfg_a[0].else_mask = r.emask;
    cfg_a[0].else_val = r.emask;
    manual_a = r.man;
    slow = r.slow;
    skew = r.skew;
    pulse_start;
    go = 1'h1;
    wait_until(a_arm, 200);
    chk_val(16'(a_addr), 16'(r.exp_addr));
    chk_val(16'(a_tag), count_time ? 16'(r.exp_addr) : 16'h0000);
    chk_bit(b_arm, 1'h0);
    n = 0;
    d = 0;
    fork
      for (int c = 0; c < 200 && a_done !== 1'h1; c++) begin
        tick;
        n += int'(a_store === 1'h1);
      end
      for (int c = 0; c < 20 && scope_arm_out !== 1'h1; c++) begin
        tick;
        d++;
      end
    join
    chk_val(16'(n), 16'(r.exp_cnt));
    chk_val(16'(d), 16'(`SKEW_MAX - r.skew + 2));
    chk_bit(b_arm, exp_b);
    pulse_end;
    chk_bit(a_arm, 1'h0);
  endtask

  task automatic wrap_up;
    if (mismatches == 0 && cmp_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Cuts a hung run short.
  initial begin
    #(6000 * 50);
    mismatches++;
    wrap_up;
  end

  // ****************************************************************
  // Main sequence.
  // ****************************************************************
  initial begin
    rst = 1'h1;
    {run_start, run_end, count_time, b_timing, manual_a} = '0;
    {manual_b, glitch_mode, pod_toggle, scope_input_one} = '0;
    {cfg_a, cfg_b, trig_pos_b, scope_arm_sel, skew, go, slow} = '0;
    {b_valid, b_data, b_xing, edge_rise_mask, edge_fall_mask} = '0;
    edge_glitch_mask = '0;
    arm_src_a = ARM_NONE;
    arm_src_b = ARM_NONE;
    trig_pos_a = 4'hC;
    scope_edge_rise = 1'h1;
    scope_immediate = 1'h1;
    b_run = 1'h1;
    mismatches = 0;
    cmp_count = 0;
    repeat (2) @(posedge clk_sys);
    #1 rst = 1'h0;
    tick;
    chk_val(16'(rate_mhz), 16'h00FA);
    chk_bit(a_arm, 1'h0);
    foreach (rows[i]) run_row(rows[i], 1'h0);
    // Unit B as timing unit, run by unit A, needs arm and a rising edge.
    b_timing = 1'h1;
    arm_src_b = ARM_PEER;
    count_time = 1'h1;
    edge_rise_mask = 16'h0001;
    cfg_b[0].is_trig = 1'h1;
    cfg_b[0].use_edge = 1'h1;
    cfg_b[0].store_any = 1'h1;
    run_row('{16'hFFFF, 16'h0005, 8'h01, 16'h0000, 1'h0, 1'h0, 3'h7,
              4'h6, 8'h08}, 1'h1);
    // Unit A run by the scope edge trigger.
    arm_src_a = ARM_SCOPE;
    arm_src_b = ARM_NONE;
    pulse_start;
    go = 1'h1;
    repeat (4) tick;
    chk_bit(a_arm, 1'h0);
    scope_input_one = 1'h1;
    wait_until(a_arm, 10);
    chk_bit(scope_trig, 1'h1);
    chk_bit(a_arm, 1'h1);
    pulse_end;
    // Glitch mode: two crossings flag, one does not, other pod ignored.
    b_run = 1'h0;
    glitch_mode = 1'h1;
    edge_rise_mask = '0;
    edge_glitch_mask = 16'h0004;
    tick;
    b_valid = 1'h0;
    chk_val(16'(rate_mhz), 16'h007D);
    pulse_start;
    b_xing = 16'h0204;
    tick;
    b_xing = 16'h020C;
    tick;
    b_xing = '0;
    b_valid = 1'h1;
    tick;
    b_valid = 1'h0;
    tick;
    chk_val(glitch_flags, 16'h0004);
    wait_until(b_arm, 5);
    chk_bit(b_arm, 1'h1);
    pod_toggle = 1'h1;
    tick;
    pod_toggle = 1'h0;
    chk_bit(pod_sel, 1'h1);
    glitch_mode = 1'h0;
    tick;
    chk_val(16'(rate_mhz), 16'h00FA);
    wrap_up;
  end
endmodule

`default_nettype wire
